// ---- logic/ipe_regs.svh ----
`ifndef IPE_REGS_SVH
`define IPE_REGS_SVH
// Register addresses on the special function register bus.
`define IPE_ADDR_PRIO 8'hB8
`define IPE_ADDR_EN1 8'hE6
`define IPE_ADDR_EN2 8'hE7
// Reset values of the stored fields.
`define IPE_PRIO_RST 7'h00
`define IPE_EN1_RST 8'h00
`define IPE_EN2_RST 2'h0
// Priority register: top bit is unused and reads as one.
`define IPE_PRIO_TOP_BIT 7
`define IPE_PRIO_TOP_VAL 1'b1
// Extended enable one field positions.
`define IPE_EN1_TIMER3 7
`define IPE_EN1_RSVD 6
`define IPE_EN1_CMP 5
`define IPE_EN1_ADC_DONE 4
`define IPE_EN1_PCA 3
`define IPE_EN1_WINDOW 2
`define IPE_EN1_PMATCH 1
`define IPE_EN1_SMBUS 0
// Extended enable two field positions; bits 7:2 read as zero.
`define IPE_EN2_CS_GRT 1
`define IPE_EN2_CS_DONE 0
`endif

// ---- logic/ipe_pkg.sv ----
package ipe_pkg;
	// Source index doubles as the vector number and as the fixed order.
	typedef enum logic [3:0] {
		SRC_EXT0 = 4'h0, SRC_TIMER0 = 4'h1, SRC_EXT1 = 4'h2, SRC_TIMER1 = 4'h3,
		SRC_UART = 4'h4, SRC_TIMER2 = 4'h5, SRC_SPI = 4'h6, SRC_SMBUS = 4'h7,
		SRC_PMATCH = 4'h8, SRC_WINDOW = 4'h9, SRC_ADC_DONE = 4'hA, SRC_PCA = 4'hB,
		SRC_CMP = 4'hC, SRC_TIMER3 = 4'hD, SRC_CS_GRT = 4'hE, SRC_CS_DONE = 4'hF
	} ipe_src_e;
	// Service nesting level, Gray coded along none, low, high over low.
	typedef enum logic [1:0] {
		NEST_NONE = 2'b00,
		NEST_LOW = 2'b01,
		NEST_HIGH_OVER_LOW = 2'b11,
		NEST_HIGH = 2'b10
	} ipe_nest_e;
endpackage : ipe_pkg

// ---- logic/ipe_arbiter.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Fixed-order two-level selector.
// ****************************************************************
module ipe_arbiter #(
	parameter int N_SRC = 16,
	parameter int IDX_W = 4
) (
	input wire logic [N_SRC-1:0] pend_i,
	input wire logic [N_SRC-1:0] prio_i,
	output logic valid_o,
	output logic [IDX_W-1:0] idx_o,
	output logic high_o
);
	// Refuse a source count the index cannot name.
	if (N_SRC < 2 || N_SRC > (1 << IDX_W)) begin : g_chk
		$error("ipe_arbiter: N_SRC does not fit IDX_W");
	end

	logic [N_SRC-1:0] pend_hi; // Pending requests at high level.
	logic [N_SRC-1:0] pend_lo; // Pending requests at low level.
	assign pend_hi = pend_i & prio_i;
	assign pend_lo = pend_i & ~prio_i;

	// Lowest index wins within a level; high level beats low level.
	always_comb begin
		valid_o = 1'b0;
		idx_o = '0;
		high_o = 1'b0;
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (pend_lo[i]) begin
				valid_o = 1'b1;
				idx_o = IDX_W'(i);
			end
		end
		for (int i = N_SRC - 1; i >= 0; i--) begin
			if (pend_hi[i]) begin
				valid_o = 1'b1;
				idx_o = IDX_W'(i);
				high_o = 1'b1;
			end
		end
	end
endmodule : ipe_arbiter

// ---- logic/ipe_top.sv ----
`timescale 1ns/1ps
`include "ipe_regs.svh"
// Functional notes
// - Priority register top bit reads one, ignores writes.
// - Bit 6 sets serial peripheral priority.
// - Bit 5 sets timer two priority.
// - Bit 4 sets UART priority.
// - Bit 3 sets timer one priority.
// - Bit 2 sets external input one priority.
// - Bit 1 sets timer zero priority.
// - Bit 0 sets external input zero priority.
// - Enable one bit 7 gates both timer three flags.
// - Enable one bit 5 gates both comparator flags.
// - Enable one bit 4 gates conversion done.
// - Enable one bit 3 gates counter array.
// - Enable one bit 2 gates window compare.
// - Enable one bit 1 gates port match.
// - Enable one bit 0 gates SMBus.
// - Enable two bits 7:2 read zero, ignore writes.
// - Enable two bit 1 gates capsense greater.
// - Enable two bit 0 gates capsense done.
// - Global enable overrides every individual mask.
module ipe_top (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic SFR_RD_I,
	output logic [7:0] SFR_RDATA_O,
	output logic SFR_HIT_O,
	input wire logic GLOBAL_IRQ_ENABLE_I,
	input wire logic [6:0] BASIC_ENABLE_I,
	input wire logic [8:0] EXT_PRIORITY_I,
	input wire logic [6:0] BASIC_FLAGS_I,
	input wire logic TIMER_THREE_LOW_OVERFLOW_FLAG_I,
	input wire logic TIMER_THREE_HIGH_OVERFLOW_FLAG_I,
	input wire logic COMPARATOR_RISING_FLAG_I,
	input wire logic COMPARATOR_FALLING_FLAG_I,
	input wire logic CONVERSION_DONE_FLAG_I,
	input wire logic WINDOW_COMPARE_FLAG_I,
	input wire logic COUNTER_ARRAY_REQ_I,
	input wire logic PORT_MATCH_REQ_I,
	input wire logic SMBUS_REQ_I,
	input wire logic CAPSENSE_GREATER_FLAG_I,
	input wire logic CAPSENSE_DONE_FLAG_I,
	input wire logic IRQ_ACK_I,
	input wire logic IRQ_RETURN_I,
	output logic IRQ_REQ_O,
	output logic [3:0] IRQ_VECTOR_O,
	output logic IRQ_HIGH_O
);
	localparam int N_SRC = 16; // Seven basic plus nine extended sources.

	// ****************************************************************
	// Register storage and bus decode.
	// ****************************************************************
	logic [6:0] basic_source_priority_q; // Stored priority bits 6:0.
	logic [7:0] extended_source_enable_one_q; // Bit 6 is never stored.
	logic [1:0] extended_source_enable_two_q; // Only the two live bits.
	logic [7:0] rdata_q; // Registered read data.
	logic hit_q; // Registered address match for the read.

	wire sel_prio = (SFR_ADDR_I == `IPE_ADDR_PRIO); // Priority address match.
	wire sel_en1 = (SFR_ADDR_I == `IPE_ADDR_EN1); // Enable one match.
	wire sel_en2 = (SFR_ADDR_I == `IPE_ADDR_EN2); // Enable two match.
	wire sel_any = sel_prio | sel_en1 | sel_en2; // Any register of ours.
	wire wr_prio = SFR_WR_I & sel_prio; // Priority write strobe.
	wire wr_en1 = SFR_WR_I & sel_en1; // Enable one write strobe.
	wire wr_en2 = SFR_WR_I & sel_en2; // Enable two write strobe.

	// Reserved bit 6 is dropped; software is expected to write zero there.
	wire [7:0] en1_wr_val = SFR_WDATA_I & ~(8'h01 << `IPE_EN1_RSVD);

	// Read views; unused and reserved bits are constants.
	wire [7:0] prio_view = {`IPE_PRIO_TOP_VAL, basic_source_priority_q};
	wire [7:0] en2_view = {6'h00, extended_source_enable_two_q};
	wire [7:0] rdata_d = sel_prio ? prio_view :
		sel_en1 ? extended_source_enable_one_q :
		sel_en2 ? en2_view : 8'h00;

	// Priority register: the top bit has no storage so a write cannot reach it.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			basic_source_priority_q <= `IPE_PRIO_RST;
		end else if (wr_prio) begin
			basic_source_priority_q <= SFR_WDATA_I[6:0];
		end
	end

	// Enable registers; enable two keeps only bits 1:0.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			extended_source_enable_one_q <= `IPE_EN1_RST;
			extended_source_enable_two_q <= `IPE_EN2_RST;
		end else begin
			if (wr_en1) begin
				extended_source_enable_one_q <= en1_wr_val;
			end
			if (wr_en2) begin
				extended_source_enable_two_q <= SFR_WDATA_I[1:0];
			end
		end
	end

	// Read data lands one cycle after the strobe and then holds.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata_q <= 8'h00;
			hit_q <= 1'b0;
		end else if (SFR_RD_I) begin
			rdata_q <= rdata_d;
			hit_q <= sel_any;
		end
	end
	assign SFR_RDATA_O = rdata_q;
	assign SFR_HIT_O = hit_q;

	// ****************************************************************
	// Source gathering and masking.
	// ****************************************************************
	logic [N_SRC-1:0] raw_req; // Request level of each source.
	logic [N_SRC-1:0] en_vec; // Individual enable of each source.
	logic [N_SRC-1:0] prio_vec; // Priority level of each source.
	logic [N_SRC-1:0] pend; // Requests that may be offered now.
	logic [1:0] en_two;
	logic [7:0] en_one;
	assign en_one = extended_source_enable_one_q;
	assign en_two = extended_source_enable_two_q;

	// Paired flags share one enable, so either flag raises the request.
	assign raw_req = {CAPSENSE_DONE_FLAG_I, CAPSENSE_GREATER_FLAG_I,
		TIMER_THREE_LOW_OVERFLOW_FLAG_I | TIMER_THREE_HIGH_OVERFLOW_FLAG_I,
		COMPARATOR_RISING_FLAG_I | COMPARATOR_FALLING_FLAG_I,
		COUNTER_ARRAY_REQ_I, CONVERSION_DONE_FLAG_I, WINDOW_COMPARE_FLAG_I,
		PORT_MATCH_REQ_I, SMBUS_REQ_I, BASIC_FLAGS_I};

	// Enables in source order; the extended bits come from our registers.
	assign en_vec = {en_two[`IPE_EN2_CS_DONE],
		en_two[`IPE_EN2_CS_GRT],
		en_one[`IPE_EN1_TIMER3],
		en_one[`IPE_EN1_CMP],
		en_one[`IPE_EN1_PCA],
		en_one[`IPE_EN1_ADC_DONE],
		en_one[`IPE_EN1_WINDOW],
		en_one[`IPE_EN1_PMATCH],
		en_one[`IPE_EN1_SMBUS],
		BASIC_ENABLE_I};

	// Basic priorities map bit for bit onto sources 0 to 6.
	assign prio_vec = {EXT_PRIORITY_I, basic_source_priority_q};

	ipe_pkg::ipe_nest_e nest_q; // Current service nesting.
	ipe_pkg::ipe_nest_e nest_d;
	// Nothing may interrupt high service; low service admits only high.
	wire allow_low = (nest_q == ipe_pkg::NEST_NONE);
	wire allow_high = allow_low | (nest_q == ipe_pkg::NEST_LOW);

	// Per-source qualification with the global enable in front of all.
	for (genvar i = 0; i < N_SRC; i++) begin : g_src
		assign pend[i] = raw_req[i] & en_vec[i] & GLOBAL_IRQ_ENABLE_I &
			(prio_vec[i] ? allow_high : allow_low);
	end

	// ****************************************************************
	// Selection and nesting.
	// ****************************************************************
	logic sel_valid;
	logic [3:0] sel_idx;
	logic sel_high;

	ipe_arbiter #(
		.N_SRC(N_SRC),
		.IDX_W(4)
	) ipe_arbiter_i (
		.pend_i(pend),
		.prio_i(prio_vec),
		.valid_o(sel_valid),
		.idx_o(sel_idx),
		.high_o(sel_high)
	);

	logic req_q;
	logic [3:0] vec_q;
	logic high_q;
	wire take = IRQ_ACK_I & req_q; // A vectoring taken by the core.

	// Nesting walks up on a taken vector and down on return.
	always_comb begin
		nest_d = nest_q;
		case (nest_q)
			ipe_pkg::NEST_NONE: begin
				if (take) begin
					nest_d = high_q ? ipe_pkg::NEST_HIGH : ipe_pkg::NEST_LOW;
				end
			end
			ipe_pkg::NEST_LOW: begin
				if (take && high_q) begin
					nest_d = ipe_pkg::NEST_HIGH_OVER_LOW;
				end else if (IRQ_RETURN_I) begin
					nest_d = ipe_pkg::NEST_NONE;
				end
			end
			ipe_pkg::NEST_HIGH_OVER_LOW: begin
				if (IRQ_RETURN_I) begin
					nest_d = ipe_pkg::NEST_LOW;
				end
			end
			ipe_pkg::NEST_HIGH: begin
				if (IRQ_RETURN_I) begin
					nest_d = ipe_pkg::NEST_NONE;
				end
			end
			default: begin
				nest_d = ipe_pkg::NEST_NONE;
			end
		endcase
	end

	// Nesting state register.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			nest_q <= ipe_pkg::NEST_NONE;
		end else begin
			nest_q <= nest_d;
		end
	end

	// The offer is dropped in the taking cycle, because the flag of the
	// taken source is still high and would otherwise be offered twice.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			req_q <= 1'b0;
			vec_q <= 4'h0;
			high_q <= 1'b0;
		end else begin
			req_q <= sel_valid & ~take;
			vec_q <= sel_idx;
			high_q <= sel_high;
		end
	end
	assign IRQ_REQ_O = req_q;
	assign IRQ_VECTOR_O = vec_q;
	assign IRQ_HIGH_O = high_q;

	// ****************************************************************
	// Checks.
	// ****************************************************************
	logic [N_SRC-1:0] en_prev_q; // Enables as seen by the last offer.
	logic [N_SRC-1:0] prio_prev_q; // Priorities as seen by the last offer.
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			en_prev_q <= '0;
			prio_prev_q <= '0;
		end else begin
			en_prev_q <= en_vec;
			prio_prev_q <= prio_vec;
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	property p_prio_top_one;
		SFR_RD_I && sel_prio |=> SFR_RDATA_O[7] && SFR_HIT_O;
	endproperty
	a_prio_top_one: assert property (p_prio_top_one)
		else $error("Priority top bit did not read one.");

	property p_prio_level;
		IRQ_REQ_O |-> IRQ_HIGH_O == prio_prev_q[IRQ_VECTOR_O];
	endproperty
	a_prio_level: assert property (p_prio_level)
		else $error("Offered level differs from priority bit.");

	property p_ext_gate;
		IRQ_REQ_O |-> en_prev_q[IRQ_VECTOR_O];
	endproperty
	a_ext_gate: assert property (p_ext_gate)
		else $error("Masked source was offered.");

	property p_en2_upper_zero;
		SFR_RD_I && sel_en2 ##1 1'b1 |-> SFR_RDATA_O[7:2] == 6'h00;
	endproperty
	a_en2_upper_zero: assert property (p_en2_upper_zero)
		else $error("Enable two upper bits not zero.");

	property p_global_off;
		!GLOBAL_IRQ_ENABLE_I [*2] |-> !IRQ_REQ_O;
	endproperty
	a_global_off: assert property (p_global_off)
		else $error("Request offered with global enable off.");

	property p_global_on;
		GLOBAL_IRQ_ENABLE_I && raw_req[0] && en_vec[0] && nest_q == ipe_pkg::NEST_NONE
			&& !take |=> IRQ_REQ_O;
	endproperty
	a_global_on: assert property (p_global_on)
		else $error("Enabled request was not offered.");

	property p_no_preempt_high;
		$past(nest_q == ipe_pkg::NEST_HIGH || nest_q == ipe_pkg::NEST_HIGH_OVER_LOW) |-> !IRQ_REQ_O;
	endproperty
	a_no_preempt_high: assert property (p_no_preempt_high)
		else $error("High service was preempted.");

	// An offer made while low service runs must be a high one.
	property p_low_only_high;
		$past(nest_q == ipe_pkg::NEST_LOW) && IRQ_REQ_O |-> IRQ_HIGH_O;
	endproperty
	a_low_only_high: assert property (p_low_only_high)
		else $error("Low service preempted by a low request.");

	// A high offer taken during low service nests over it.
	property p_low_nests_high;
		nest_q == ipe_pkg::NEST_LOW && IRQ_REQ_O && IRQ_ACK_I |=> nest_q == ipe_pkg::NEST_HIGH_OVER_LOW;
	endproperty
	a_low_nests_high: assert property (p_low_nests_high)
		else $error("Taken high request did not nest over low service.");
endmodule : ipe_top

// ---- tb/ipe_core_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Core side model: takes offered vectors after a chosen wait.
// ****************************************************************
module ipe_core_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic req_i,
	input wire logic [3:0] vec_i,
	input wire logic high_i,
	input wire logic ack_en_i,
	input wire logic [3:0] dly_i,
	output logic ack_o,
	output logic [3:0] got_vec_o,
	output logic got_high_o,
	output logic [7:0] takes_o
);
	logic [3:0] wait_q; // Cycles the current offer has stood unanswered.
	// One ack per offer; the ack_o guard stops a second take while the offer drops.
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_o <= 1'b0;
			wait_q <= 4'h0;
			got_vec_o <= 4'h0;
			got_high_o <= 1'b0;
			takes_o <= 8'h00;
		end else if (ack_o) begin
			ack_o <= 1'b0;
		end else if (ack_en_i && req_i) begin
			if (wait_q == dly_i) begin
				ack_o <= 1'b1;
				wait_q <= 4'h0;
				got_vec_o <= vec_i;
				got_high_o <= high_i;
				takes_o <= takes_o + 8'h01;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end else begin
			wait_q <= 4'h0;
		end
	end
endmodule : ipe_core_model

// ---- tb/ipe_top_test.sv ----
`timescale 1ns/1ps
`include "ipe_regs.svh"
module ipe_top_test;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic hit;
	logic gie = 1'b0;
	logic [6:0] ben = 7'h00;
	logic [8:0] eprio = 9'h000;
	logic [6:0] bflags = 7'h00;
	logic [10:0] xf = 11'h000; // Extended flags in the order of the tables below.
	logic ack;
	logic ret = 1'b0;
	logic req;
	logic [3:0] vec;
	logic high;
	logic ack_en = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [3:0] got_vec;
	logic got_high;
	logic [7:0] takes;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [3:0] vec_tab [11] = '{4'hD, 4'hD, 4'hC, 4'hC, 4'hA, 4'h9, 4'hB, 4'h8, 4'h7, 4'hE, 4'hF};
	logic [2:0] bit_tab [11] = '{3'h7, 3'h7, 3'h5, 3'h5, 3'h4, 3'h2, 3'h3, 3'h1, 3'h0, 3'h1, 3'h0};

	always #5 clk = ~clk;

	ipe_top ipe_top_i (.CLK_SYS_I(clk), .RSTN_I(rstn), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
		.SFR_WDATA_I(wdata), .SFR_RD_I(rd), .SFR_RDATA_O(rdata), .SFR_HIT_O(hit),
		.GLOBAL_IRQ_ENABLE_I(gie), .BASIC_ENABLE_I(ben), .EXT_PRIORITY_I(eprio), .BASIC_FLAGS_I(bflags),
		.TIMER_THREE_LOW_OVERFLOW_FLAG_I(xf[0]), .TIMER_THREE_HIGH_OVERFLOW_FLAG_I(xf[1]),
		.COMPARATOR_RISING_FLAG_I(xf[2]), .COMPARATOR_FALLING_FLAG_I(xf[3]), .CONVERSION_DONE_FLAG_I(xf[4]),
		.WINDOW_COMPARE_FLAG_I(xf[5]), .COUNTER_ARRAY_REQ_I(xf[6]), .PORT_MATCH_REQ_I(xf[7]),
		.SMBUS_REQ_I(xf[8]), .CAPSENSE_GREATER_FLAG_I(xf[9]), .CAPSENSE_DONE_FLAG_I(xf[10]),
		.IRQ_ACK_I(ack), .IRQ_RETURN_I(ret), .IRQ_REQ_O(req), .IRQ_VECTOR_O(vec), .IRQ_HIGH_O(high));

	ipe_core_model ipe_core_model_i (.clk_i(clk), .rstn_i(rstn), .req_i(req), .vec_i(vec), .high_i(high),
		.ack_en_i(ack_en), .dly_i(dly), .ack_o(ack), .got_vec_o(got_vec), .got_high_o(got_high),
		.takes_o(takes));

	// ****************************************************************
	// Shared tasks. All but conclude are entered and left 1 ns after a rising edge; the watchdog enters conclude on the edge itself.
	// ****************************************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		// An idle edge keeps the next strobe out of this time step.
		cyc(1);
	endtask : wr_reg

	// Read data and hit are settled 1 ns after the read edge.
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic h);
		addr = a;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		check("read data", rdata, exp);
		check("read hit", {7'h00, hit}, {7'h00, h});
		// An idle edge keeps the next strobe out of this time step.
		cyc(1);
	endtask : rd_chk

	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic t_regs();
		rd_chk(`IPE_ADDR_PRIO, 8'h80, 1'b1);
		rd_chk(`IPE_ADDR_EN2, 8'h00, 1'b1);
		rd_chk(8'h55, 8'h00, 1'b0);
		wr_reg(`IPE_ADDR_PRIO, 8'h7F);
		rd_chk(`IPE_ADDR_PRIO, 8'hFF, 1'b1);
		wr_reg(`IPE_ADDR_PRIO, 8'h00);
		rd_chk(`IPE_ADDR_PRIO, 8'h80, 1'b1);
		wr_reg(`IPE_ADDR_EN1, 8'hBF);
		rd_chk(`IPE_ADDR_EN1, 8'hBF, 1'b1);
		wr_reg(`IPE_ADDR_EN2, 8'hFF);
		rd_chk(`IPE_ADDR_EN2, 8'h03, 1'b1);
		wr_reg(`IPE_ADDR_EN1, 8'h00);
		wr_reg(`IPE_ADDR_EN2, 8'h00);
		$display("test regs done");
	endtask : t_regs

	// Each extended flag is blocked, passed, then blocked again by the global enable.
	task automatic t_gate();
		logic [7:0] a;
		gie = 1'b1;
		eprio = 9'h1FF;
		for (int k = 0; k < 11; k++) begin
			a = (k < 9) ? `IPE_ADDR_EN1 : `IPE_ADDR_EN2;
			xf[k] = 1'b1;
			cyc(2);
			check("blocked req", {7'h00, req}, 8'h00);
			wr_reg(a, 8'h01 << bit_tab[k]);
			cyc(2);
			check("gated req", {7'h00, req}, 8'h01);
			check("gated vector", {4'h0, vec}, {4'h0, vec_tab[k]});
			check("gated level", {7'h00, high}, 8'h01);
			gie = 1'b0;
			cyc(2);
			check("global off req", {7'h00, req}, 8'h00);
			gie = 1'b1;
			xf[k] = 1'b0;
			wr_reg(a, 8'h00);
		end
		eprio = 9'h000;
		$display("test gate done");
	endtask : t_gate

	// All basic sources pend; the single high one must win over lower indices.
	task automatic t_prio();
		ben = 7'h7F;
		bflags = 7'h7F;
		for (int i = 0; i < 7; i++) begin
			wr_reg(`IPE_ADDR_PRIO, 8'h01 << i);
			cyc(2);
			check("prio vector", {4'h0, vec}, i[7:0]);
			check("prio level", {7'h00, high}, 8'h01);
			rd_chk(`IPE_ADDR_PRIO, 8'h80 | (8'h01 << i), 1'b1);
		end
		wr_reg(`IPE_ADDR_PRIO, 8'h00);
		cyc(2);
		check("low vector", {4'h0, vec}, 8'h00);
		check("low level", {7'h00, high}, 8'h00);
		bflags = 7'h00;
		cyc(2);
		$display("test prio done");
	endtask : t_prio

	task automatic t_nest();
		wr_reg(`IPE_ADDR_PRIO, 8'h02);
		bflags = 7'h01;
		ack_en = 1'b1;
		cyc(4);
		check("first take", takes, 8'h01);
		check("first vector", {4'h0, got_vec}, 8'h00);
		bflags = 7'h09;
		cyc(4);
		check("equal level held", {7'h00, req}, 8'h00);
		bflags = 7'h0B;
		dly = 4'h3;
		cyc(8);
		check("preempt take", takes, 8'h02);
		check("preempt vector", {got_high, 3'h0, got_vec}, 8'h81);
		bflags = 7'h09;
		ret = 1'b1;
		cyc(1);
		ret = 1'b0;
		cyc(8);
		check("still in low", takes, 8'h02);
		ret = 1'b1;
		cyc(1);
		ret = 1'b0;
		cyc(8);
		check("resume take", {takes[3:0], got_vec}, 8'h30);
		ack_en = 1'b0;
		bflags = 7'h00;
		ret = 1'b1;
		cyc(1);
		ret = 1'b0;
		$display("test nest done");
	endtask : t_nest

	// A hang counts as a mismatch and ends the run through the same report.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		cyc(3);
		rstn = 1'b1;
		t_regs();
		t_gate();
		t_prio();
		t_nest();
		conclude();
	end
endmodule : ipe_top_test
